// ---- rtl/lfc_top.sv ----
// lfc_top: fault setup register, fault latch, transmitter enable and alarm pin control
//
// How it works
// - the drive-select field, bits 9:8 reset 00, picks open drain, open drain with weak or strong pull-up, or push-pull.
// - with the loop enable bit 7 set (reset 1) the loop refreshes bias and modulation settings every cycle.
// - with the loop enable bit clear the loop stops and host writes alone set bias and modulation.
// - with auto-shutdown bit 6 set (reset 1) a fault turns the transmitter off at once.
// - with auto-shutdown clear the laser keeps running after a fault; the host drops the enable pin or soft enable.
// - polarity bit 5 (reset 1) makes the alarm pin active high when set, active low when clear.
// - with override bit 4 clear (reset 0) a latched fault drives the alarm pin active.
// - with override set faults still latch but the pin stays inactive unless forced.
// - force bit 3 (reset 0) drives the pin active or inactive, only while override is set.
// - bit 2 (reset 1) enables overpower fault detection.
// - bit 1 (reset 1) enables underpower fault detection.
// - bit 0 (reset 1) enables overcurrent fault detection.
// - the transmitter is on only while the enable pin and soft enable are active and, with auto-shutdown set, no fault holds.
// - a fault always latches the faulted state but stops the transmitter only with auto-shutdown set.
`timescale 1ns/1ps
`default_nettype none
module lfc_top
    import lfc_pkg::*;
#(
    parameter int SET_WIDTH = SET_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // host register access, already framed by the serial interface
    input wire logic [CMD_W-1:0] host_cmd,
    input wire logic host_wr,
    input wire logic [DATA_W-1:0] host_wr_data,
    input wire logic host_rd,
    output logic [DATA_W-1:0] host_rd_data,
    output logic host_rd_valid,
    // transmitter enables
    input wire logic en_pin,
    input wire logic soft_tx_en,
    // raw fault detectors from the analog side
    input wire logic overpower_det,
    input wire logic underpower_det,
    input wire logic overcurrent_det,
    // power loop results
    input wire logic [SET_WIDTH-1:0] loop_bias,
    input wire logic [SET_WIDTH-1:0] loop_mod,
    // laser current settings and status
    output logic [SET_WIDTH-1:0] bias_current_setting,
    output logic [SET_WIDTH-1:0] modulation_current_setting,
    output logic tx_enable,
    output logic faulted,
    // alarm pin
    output logic alarm_o,
    output logic alarm_oe,
    output logic pullup_weak_en,
    output logic pullup_strong_en
);

    // settings live in the low bits of a 16-bit host word; wider ones cannot be written
    if (SET_WIDTH < 1 || SET_WIDTH > DATA_W) begin : g_width_check
        $error("SET_WIDTH must be 1 to 16");
    end

    // ---------------------------------------------------------------
    // pin synchronisers: three stages, change accepted when 2 and 3 agree
    // ---------------------------------------------------------------
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] sync3_q;
    logic [3:0] pins_q;
    wire [3:0] pins_raw = {en_pin, overcurrent_det, underpower_det, overpower_det};
    wire [3:0] pins_agree = ~(sync2_q ^ sync3_q);
    wire [3:0] pins_d = (pins_agree & sync3_q) | (~pins_agree & pins_q);

    // the first stage feeds only the second; detectors glitch near thresholds
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
            pins_q <= 4'h0;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pins_q <= pins_d;
        end
    end

    wire overpower_s = pins_q[0];
    wire underpower_s = pins_q[1];
    wire overcurrent_s = pins_q[2];
    wire en_pin_s = pins_q[3];

    // ---------------------------------------------------------------
    // fault setup register
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] setup_q;
    wire wr_setup = host_wr && (host_cmd == CMD_FAULT_SETUP);
    wire wr_bias = host_wr && (host_cmd == CMD_BIAS_SET);
    wire wr_mod = host_wr && (host_cmd == CMD_MOD_SET);
    wire [DATA_W-1:0] setup_d = wr_setup ? (host_wr_data & FAULT_SETUP_MASK) : setup_q;

    // reserved bits never store, so they read back as zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            setup_q <= FAULT_SETUP_RESET;
        end else begin
            setup_q <= setup_d;
        end
    end

    // named views of the fields
    wire loop_en = setup_q[LOOP_EN_BIT];
    wire auto_off = setup_q[AUTO_OFF_BIT];
    wire pol_high = setup_q[POLARITY_BIT];
    wire override = setup_q[OVERRIDE_BIT];
    wire force_lvl = setup_q[FORCE_BIT];
    wire overpwr_en = setup_q[OVERPWR_EN_BIT];
    wire underpwr_en = setup_q[UNDERPWR_EN_BIT];
    wire overcur_en = setup_q[OVERCUR_EN_BIT];

    // ---------------------------------------------------------------
    // bias and modulation settings
    // ---------------------------------------------------------------
    logic [SET_WIDTH-1:0] bias_d;
    logic [SET_WIDTH-1:0] mod_d;

    // loop wins over the host: a host write while the loop runs is never taken
    assign bias_d = loop_en ? loop_bias : (wr_bias ? host_wr_data[SET_WIDTH-1:0] : bias_current_setting);
    assign mod_d = loop_en ? loop_mod : (wr_mod ? host_wr_data[SET_WIDTH-1:0] : modulation_current_setting);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bias_current_setting <= '0;
            modulation_current_setting <= '0;
        end else begin
            bias_current_setting <= bias_d;
            modulation_current_setting <= mod_d;
        end
    end

    // ---------------------------------------------------------------
    // fault detection and transmitter state
    // ---------------------------------------------------------------
    wire fault_evt = (overpower_s & overpwr_en)
        | (underpower_s & underpwr_en)
        | (overcurrent_s & overcur_en);
    wire tx_request = en_pin_s & soft_tx_en;

    lfc_tx_e tx_q;
    lfc_tx_e tx_d;

    // faulted clears only once the host drops the request and the fault is gone
    // no repeat-fault counting: a detector that chatters simply latches the fault again
    always_comb begin
        tx_d = tx_q;
        case (tx_q)
            LFC_TX_OFF: begin
                if (fault_evt) begin
                    tx_d = LFC_TX_FAULTED;
                end else if (tx_request) begin
                    tx_d = LFC_TX_ON;
                end
            end
            LFC_TX_ON: begin
                if (fault_evt) begin
                    tx_d = LFC_TX_FAULTED;
                end else if (!tx_request) begin
                    tx_d = LFC_TX_OFF;
                end
            end
            LFC_TX_FAULTED: begin
                if (!tx_request && !fault_evt) begin
                    tx_d = LFC_TX_OFF; // set wins over clear
                end
            end
            default: begin
                tx_d = LFC_TX_OFF;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_q <= LFC_TX_OFF;
        end else begin
            tx_q <= tx_d;
        end
    end

    // without auto-shutdown a faulted laser keeps running while requested
    wire is_faulted = (tx_q == LFC_TX_FAULTED);
    wire tx_on_d = tx_request & (~is_faulted | ~auto_off) & ~(fault_evt & auto_off);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_enable <= 1'b0;
            faulted <= 1'b0;
        end else begin
            tx_enable <= tx_on_d;
            faulted <= is_faulted;
        end
    end

    // ---------------------------------------------------------------
    // alarm pin level
    // ---------------------------------------------------------------
    wire alarm_active = override ? force_lvl : faulted;
    wire alarm_level = pol_high ? alarm_active : ~alarm_active;

    lfc_alarm_if alarm_req ();
    assign alarm_req.drive_mode = lfc_drive_e'(setup_q[DRV_MSB:DRV_LSB]);
    assign alarm_req.pin_level = alarm_level;

    lfc_alarm_pad u_pad (
        .ref_clk(ref_clk),
        .reset(reset),
        .req(alarm_req),
        .alarm_o(alarm_o),
        .alarm_oe(alarm_oe),
        .pullup_weak_en(pullup_weak_en),
        .pullup_strong_en(pullup_strong_en)
    );

    // ---------------------------------------------------------------
    // host reads, answered one edge after the request
    // ---------------------------------------------------------------
    wire [DATA_W-1:0] state_word = DATA_W'({alarm_active, en_pin_s, faulted, tx_enable});
    wire [DATA_W-1:0] bias_word = DATA_W'(bias_current_setting);
    wire [DATA_W-1:0] mod_word = DATA_W'(modulation_current_setting);
    wire [DATA_W-1:0] rd_sel = (host_cmd == CMD_FAULT_SETUP) ? setup_q :
        (host_cmd == CMD_BIAS_SET) ? bias_word :
        (host_cmd == CMD_MOD_SET) ? mod_word :
        (host_cmd == CMD_STATE) ? state_word : 16'h0000;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            host_rd_data <= 16'h0000;
            host_rd_valid <= 1'b0;
        end else begin
            host_rd_data <= host_rd ? rd_sel : host_rd_data;
            host_rd_valid <= host_rd;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // every check waits out reset; the pad adds one register stage behind the core
    drive_field_a: assert property (wr_setup |=> ##1
        (pullup_weak_en == ($past(host_wr_data[DRV_MSB:DRV_LSB], 2) == 2'h1)))
        else $error("drive mode did not follow the written field");
    loop_refresh_a: assert property (loop_en |=> bias_current_setting == $past(loop_bias))
        else $error("loop value not taken into bias setting");
    mod_refresh_a: assert property (loop_en |=> modulation_current_setting == $past(loop_mod))
        else $error("loop value not taken into modulation setting");
    host_owns_a: assert property (!loop_en && !wr_bias |=> $stable(bias_current_setting))
        else $error("bias setting moved without a host write");
    host_mod_a: assert property (!loop_en && wr_mod |=>
        modulation_current_setting == $past(host_wr_data[SET_WIDTH-1:0]))
        else $error("host write not taken into modulation setting");
    auto_off_a: assert property (auto_off && fault_evt |=> !tx_enable)
        else $error("transmitter still on after fault with auto shutdown");
    keep_running_a: assert property (!auto_off && tx_request |=> tx_enable)
        else $error("transmitter dropped without auto shutdown");
    polarity_a: assert property (!override && faulted && $stable(setup_q) |->
        alarm_req.pin_level == pol_high)
        else $error("alarm level ignores polarity");
    fault_alarm_a: assert property (!override && pol_high && faulted |=> alarm_o || !alarm_oe)
        else $error("fault did not reach the alarm pin");
    override_quiet_a: assert property (override && !force_lvl |-> alarm_level == !pol_high)
        else $error("override left the alarm active");
    force_level_a: assert property (override |-> alarm_active == force_lvl)
        else $error("forced level not shown");
    overpwr_mask_a: assert property ((!overpower_s || !overpwr_en) &&
        (!underpower_s || !underpwr_en) && (!overcurrent_s || !overcur_en)
        && tx_q != LFC_TX_FAULTED |=> tx_q != LFC_TX_FAULTED)
        else $error("masked detector raised a fault");
    fault_latch_a: assert property (fault_evt |=> is_faulted ##1 faulted)
        else $error("fault not latched");
    fault_hold_a: assert property (is_faulted && (tx_request || fault_evt) |=> is_faulted)
        else $error("faulted state left too early");
    tx_gate_a: assert property (!tx_request |=> !tx_enable)
        else $error("transmitter on without request");
    readback_a: assert property (wr_setup ##1 !host_wr ##1
        (host_rd && host_cmd == CMD_FAULT_SETUP && !host_wr)
        |=> host_rd_valid && host_rd_data == ($past(host_wr_data, 3) & FAULT_SETUP_MASK))
        else $error("setup register readback mismatch");
    reserved_zero_a: assert property (setup_q[DATA_W-1:DRV_MSB+1] == '0)
        else $error("reserved setup bits stored a value");
    rd_answer_a: assert property (host_rd |=> host_rd_valid)
        else $error("read not answered in the next cycle");

    // main scenarios the bench is expected to reach
    fault_seen_c: cover property (tx_enable ##1 fault_evt ##2 faulted);
    override_force_c: cover property (override && force_lvl && faulted);
    host_bias_c: cover property (!loop_en && wr_bias);
    no_autooff_c: cover property (faulted && tx_enable);
    masked_c: cover property (overpower_s && !overpwr_en && !faulted);

endmodule : lfc_top
`default_nettype wire

// ---- shared/lfc_pkg.sv ----
// lfc_pkg: constants shared by the laser fault configuration block
package lfc_pkg;

    // host command codes and data widths
    localparam int CMD_W = 8;
    localparam int DATA_W = 16;
    localparam int SET_W = 10;
    localparam logic [7:0] CMD_FAULT_SETUP = 8'h13;
    localparam logic [7:0] CMD_BIAS_SET = 8'h20; // bias current setting
    localparam logic [7:0] CMD_MOD_SET = 8'h21; // modulation current setting
    localparam logic [7:0] CMD_STATE = 8'h22; // block state readback

    // fault setup register fields
    localparam int DRV_LSB = 8;
    localparam int DRV_MSB = 9;
    localparam int LOOP_EN_BIT = 7;
    localparam int AUTO_OFF_BIT = 6;
    localparam int POLARITY_BIT = 5;
    localparam int OVERRIDE_BIT = 4;
    localparam int FORCE_BIT = 3;
    localparam int OVERPWR_EN_BIT = 2;
    localparam int UNDERPWR_EN_BIT = 1;
    localparam int OVERCUR_EN_BIT = 0;
    localparam logic [15:0] FAULT_SETUP_MASK = 16'h03ff;
    localparam logic [15:0] FAULT_SETUP_RESET = 16'h00e7;

    // state readback fields
    localparam int ST_TX_EN_BIT = 0;
    localparam int ST_FAULTED_BIT = 1;
    localparam int ST_EN_PIN_BIT = 2;
    localparam int ST_ALARM_BIT = 3;

    // alarm pin drive modes
    typedef enum logic [1:0] {
        LFC_DRV_OD = 2'h0,
        LFC_DRV_OD_WEAK = 2'h1,
        LFC_DRV_OD_STRONG = 2'h2,
        LFC_DRV_PUSH_PULL = 2'h3
    } lfc_drive_e;

    // transmitter state, gray coded along off -> on -> faulted
    typedef enum logic [1:0] {
        LFC_TX_OFF = 2'h0,
        LFC_TX_ON = 2'h1,
        LFC_TX_FAULTED = 2'h3
    } lfc_tx_e;

    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 3;

endpackage : lfc_pkg

// ---- shared/lfc_alarm_if.sv ----
// lfc_alarm_if: alarm pin request from the control core to the pad driver
`timescale 1ns/1ps
`default_nettype none
interface lfc_alarm_if;
    import lfc_pkg::*;
    lfc_drive_e drive_mode;
    logic pin_level; // level the pin should show
    modport ctl (output drive_mode, output pin_level);
    modport drv (input drive_mode, input pin_level);
endinterface : lfc_alarm_if
`default_nettype wire

// ---- rtl/lfc_alarm_pad.sv ----
// lfc_alarm_pad: alarm pin driver for open drain and push-pull modes
`timescale 1ns/1ps
`default_nettype none
module lfc_alarm_pad
    import lfc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // request from the core
    lfc_alarm_if.drv req,
    // pin signals
    output logic alarm_o,
    output logic alarm_oe,
    output logic pullup_weak_en,
    output logic pullup_strong_en
);

    // decoded drive per mode; open drain only ever pulls low
    wire push_pull = (req.drive_mode == LFC_DRV_PUSH_PULL);
    wire oe_d = push_pull ? 1'b1 : ~req.pin_level;
    wire o_d = push_pull ? req.pin_level : 1'b0;
    wire weak_d = (req.drive_mode == LFC_DRV_OD_WEAK);
    wire strong_d = (req.drive_mode == LFC_DRV_OD_STRONG);

    // registered pad controls; after reset the pin is released and high
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            alarm_o <= 1'b0;
            alarm_oe <= 1'b0;
            pullup_weak_en <= 1'b0;
            pullup_strong_en <= 1'b0;
        end else begin
            alarm_o <= o_d;
            alarm_oe <= oe_d;
            pullup_weak_en <= weak_d;
            pullup_strong_en <= strong_d;
        end
    end

    // pad follows the requested drive mode one edge later
    pushpull_drive_a: assert property (@(posedge ref_clk) disable iff (reset)
        push_pull |=> alarm_oe && (alarm_o == $past(req.pin_level)))
        else $error("push-pull mode did not drive the pin");
    open_drain_a: assert property (@(posedge ref_clk) disable iff (reset)
        !push_pull |=> !alarm_o && (alarm_oe == !$past(req.pin_level)))
        else $error("open drain mode drove the pin high");

endmodule : lfc_alarm_pad
`default_nettype wire

// ---- verification/lfc_host_model.sv ----
// lfc_host_model: host processor issuing register writes and reads to the fault block
`timescale 1ns/1ps
`default_nettype none
module lfc_host_model
    import lfc_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // register access
    output logic [CMD_W-1:0] host_cmd,
    output logic host_wr,
    output logic [DATA_W-1:0] host_wr_data,
    output logic host_rd,
    input wire logic [DATA_W-1:0] host_rd_data,
    input wire logic host_rd_valid
);
    // quiet bus at time zero
    initial begin
        host_cmd = 8'h00;
        host_wr = 1'b0;
        host_wr_data = 16'h0000;
        host_rd = 1'b0;
    end

    // one write strobe; the idle bus shows the inverse so stale data never looks fresh
    task automatic write_reg(input logic [CMD_W-1:0] cmd, input logic [DATA_W-1:0] data);
        @(negedge ref_clk);
        host_cmd = cmd;
        host_wr_data = data;
        host_wr = 1'b1;
        @(negedge ref_clk);
        host_wr = 1'b0;
        host_cmd = ~cmd;
        host_wr_data = ~data;
    endtask : write_reg

    // one-cycle read strobe, command held until the answer is seen
    task automatic read_reg(input logic [CMD_W-1:0] cmd, output logic [DATA_W-1:0] data, output logic ok);
        int n;
        ok = 1'b0;
        data = 16'h0000;
        @(negedge ref_clk);
        host_cmd = cmd;
        host_rd = 1'b1;
        for (n = 0; n < 4 && ok == 1'b0; n++) begin
            @(negedge ref_clk);
            host_rd = 1'b0;
            if (host_rd_valid === 1'b1) begin
                ok = 1'b1;
                data = host_rd_data;
            end
        end
        host_cmd = ~cmd;
    endtask : read_reg
endmodule : lfc_host_model
`default_nettype wire

// ---- verification/laser_fault_config_bench.sv ----
// laser_fault_config_bench: register, pin and fault checks for the fault setup block
`timescale 1ns/1ps
`default_nettype none
module laser_fault_config_bench;
    import lfc_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [CMD_W-1:0] host_cmd;
    logic host_wr;
    logic [DATA_W-1:0] host_wr_data;
    logic host_rd;
    logic [DATA_W-1:0] host_rd_data;
    logic host_rd_valid;
    logic en_pin;
    logic soft_tx_en;
    logic overpower_det;
    logic underpower_det;
    logic overcurrent_det;
    logic [9:0] loop_bias;
    logic [9:0] loop_mod;
    logic [9:0] bias_current_setting;
    logic [9:0] modulation_current_setting;
    logic tx_enable;
    logic faulted;
    logic alarm_o;
    logic alarm_oe;
    logic pullup_weak_en;
    logic pullup_strong_en;
    logic [15:0] cur_setup;
    int err_total = 0;
    int tests_run = 0;

    // 125 MHz reference clock
    always #4 ref_clk = ~ref_clk;

    lfc_top lfc_top_inst (.ref_clk(ref_clk), .reset(reset), .host_cmd(host_cmd), .host_wr(host_wr),
        .host_wr_data(host_wr_data), .host_rd(host_rd), .host_rd_data(host_rd_data),
        .host_rd_valid(host_rd_valid), .en_pin(en_pin), .soft_tx_en(soft_tx_en),
        .overpower_det(overpower_det), .underpower_det(underpower_det), .overcurrent_det(overcurrent_det),
        .loop_bias(loop_bias), .loop_mod(loop_mod), .bias_current_setting(bias_current_setting),
        .modulation_current_setting(modulation_current_setting), .tx_enable(tx_enable), .faulted(faulted),
        .alarm_o(alarm_o), .alarm_oe(alarm_oe), .pullup_weak_en(pullup_weak_en),
        .pullup_strong_en(pullup_strong_en));

    lfc_host_model lfc_host_model_inst (.ref_clk(ref_clk), .host_cmd(host_cmd), .host_wr(host_wr),
        .host_wr_data(host_wr_data), .host_rd(host_rd), .host_rd_data(host_rd_data),
        .host_rd_valid(host_rd_valid));

    // verdict and end of run
    task automatic finish_test();
        if (err_total == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // one comparison, reported at once
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
        lfc_host_model_inst.write_reg(cmd, data);
    endtask : wr

    // read with a bounded wait for the valid pulse
    task automatic rd_chk(input string what, input logic [7:0] cmd, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        lfc_host_model_inst.read_reg(cmd, d, ok);
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH %s expected valid seen none", what);
            finish_test();
        end
        chk(what, exp, d);
    endtask : rd_chk

    // write setup, then allow the two cycles the pad needs plus one
    task automatic set_up(input logic [15:0] v);
        cur_setup = v;
        wr(CMD_FAULT_SETUP, v);
        repeat (3) @(negedge ref_clk);
    endtask : set_up

    // pin level the host should see for a setup word and fault state
    function automatic logic exp_pin(input logic [15:0] s, input logic flt);
        logic act;
        act = s[OVERRIDE_BIT] ? s[FORCE_BIT] : flt;
        return s[POLARITY_BIT] ? act : ~act;
    endfunction : exp_pin

    task automatic pin_chk(input string what, input logic flt);
        logic lvl;
        logic wire_lvl;
        lvl = exp_pin(cur_setup, flt);
        wire_lvl = alarm_oe ? alarm_o : 1'b1; // undriven line rests high on a pull-up
        chk(what, {15'h0, lvl}, {15'h0, wire_lvl});
        chk("pull_weak", {15'h0, cur_setup[9:8] == 2'h1}, {15'h0, pullup_weak_en});
        chk("pull_strong", {15'h0, cur_setup[9:8] == 2'h2}, {15'h0, pullup_strong_en});
        if (cur_setup[9:8] == 2'h3) begin
            chk("push_oe", 16'h0001, {15'h0, alarm_oe});
        end else begin
            chk("od_oe", {15'h0, ~lvl}, {15'h0, alarm_oe});
        end
    endtask : pin_chk

    // bounded wait on the latched fault flag
    task automatic wait_flt(input logic exp);
        int n;
        for (n = 0; n < 12 && faulted !== exp; n++) @(negedge ref_clk);
        chk("faulted", {15'h0, exp}, {15'h0, faulted});
        if (faulted !== exp) finish_test();
    endtask : wait_flt

    // faulted only clears once the request is dropped and detectors are quiet
    task automatic clear_fault();
        {overpower_det, underpower_det, overcurrent_det} = 3'b000;
        soft_tx_en = 1'b0;
        wait_flt(1'b0);
        soft_tx_en = 1'b1;
        repeat (8) @(negedge ref_clk);
    endtask : clear_fault

    // main sequence
    initial begin
        logic [15:0] s;
        int m;
        en_pin = 1'b0;
        soft_tx_en = 1'b0;
        {overpower_det, underpower_det, overcurrent_det} = 3'b000;
        loop_bias = 10'h155;
        loop_mod = 10'h0aa;
        cur_setup = FAULT_SETUP_RESET;
        repeat (5) @(negedge ref_clk);
        reset = 1'b0;
        rd_chk("setup_reset", CMD_FAULT_SETUP, 16'h00e7);
        wr(CMD_FAULT_SETUP, 16'hffff);
        rd_chk("setup_mask", CMD_FAULT_SETUP, 16'h03ff);
        rd_chk("unmapped", 8'h00, 16'h0000);
        // every drive mode, polarity, override and force with no fault
        for (m = 0; m < 32; m++) begin
            s = 16'h00c7;
            s[9:8] = m[4:3];
            s[5] = m[2];
            s[4] = m[1];
            s[3] = m[0];
            set_up(s);
            pin_chk("pin_idle", 1'b0);
        end
        // the loop owns the settings, host writes are ignored
        set_up(16'h00e7);
        wr(CMD_BIAS_SET, 16'h02aa);
        repeat (2) @(negedge ref_clk);
        chk("bias_loop", 16'h0155, {6'h0, bias_current_setting});
        loop_bias = 10'h111;
        repeat (2) @(negedge ref_clk);
        chk("bias_follow", 16'h0111, {6'h0, bias_current_setting});
        chk("mod_loop", 16'h00aa, {6'h0, modulation_current_setting});
        // with the loop off the host alone sets them; only the low ten bits count
        set_up(16'h0067);
        wr(CMD_BIAS_SET, 16'h02aa);
        wr(CMD_MOD_SET, 16'hfc33);
        loop_bias = 10'h3ff;
        loop_mod = 10'h3ff;
        repeat (2) @(negedge ref_clk);
        chk("bias_host", 16'h02aa, {6'h0, bias_current_setting});
        chk("mod_host", 16'h0033, {6'h0, modulation_current_setting});
        // fault with automatic shutdown
        set_up(16'h00e7);
        en_pin = 1'b1;
        soft_tx_en = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk("tx_on", 16'h0001, {15'h0, tx_enable});
        rd_chk("state_on", CMD_STATE, 16'h0005);
        overpower_det = 1'b1;
        wait_flt(1'b1);
        repeat (2) @(negedge ref_clk);
        chk("tx_auto_off", 16'h0000, {15'h0, tx_enable});
        pin_chk("pin_fault", 1'b1);
        clear_fault();
        // no shutdown, pin overridden: laser keeps running until the host drops its enable
        set_up(16'h00b7);
        overcurrent_det = 1'b1;
        wait_flt(1'b1);
        repeat (2) @(negedge ref_clk);
        chk("tx_kept", 16'h0001, {15'h0, tx_enable});
        pin_chk("pin_ovr", 1'b1);
        soft_tx_en = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk("tx_host_off", 16'h0000, {15'h0, tx_enable});
        clear_fault();
        // each detector is ignored while its enable is clear
        for (m = 0; m < 3; m++) begin
            set_up(16'h00e7 & ~(16'h0004 >> m));
            {overpower_det, underpower_det, overcurrent_det} = 3'b100 >> m;
            repeat (10) @(negedge ref_clk);
            chk("masked", 16'h0000, {15'h0, faulted});
            set_up(16'h00e7);
            wait_flt(1'b1);
            clear_fault();
        end
        // reset in mid-run restores the setup word
        set_up(16'h0318);
        reset = 1'b1;
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        rd_chk("setup_rst2", CMD_FAULT_SETUP, 16'h00e7);
        finish_test();
    end
endmodule : laser_fault_config_bench
`default_nettype wire
